// ---- rtl/assp_port.sv ----
/*
 Serial slave port: mode-3 SPI slave (3 or 4 wire) with register auto-increment.
 Assumes the register storage sits outside and answers rd_data combinationally
 from rd_addr; the two-wire engine sits outside and is enabled by twi_enable.
*/
// Behaviour
// - Slave only; chip-select high selects two-wire mode, low runs SPI.
// - Bit 6 of register 0x31 chooses 3-wire when set, 4-wire when clear.
// - Outputs change on falling clock edge; inputs sampled on rising edge.
// - With multi-byte flag set, address advances after every data byte.
// - Serial output stops being driven once chip-select rises.
// - While chip-select is high the two-wire slave watches the lines.
`timescale 1ns/1ps
module assp_port
	import assp_pkg::*;
(
	// System
	input  wire logic              clock,
	input  wire logic              rst,
	// Serial pins
	input  wire logic              cs_n,
	input  wire logic              sclk,
	input  wire logic              sdi,
	output logic                   sdo,
	output logic                   sdo_oe,
	input  wire logic              sdio_in,
	output logic                   sdio_out,
	output logic                   sdio_oe,
	// Two-wire engine enable
	output logic                   twi_enable,
	// Register access
	output logic [ADDR_W-1:0]      rd_addr,
	input  wire logic [7:0]        rd_data,
	output assp_wr_s               wr,
	output logic                   wr_valid
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [1:0] cs_sync_reg;
	logic [1:0] sclk_sync_reg;
	logic [1:0] sdi_sync_reg;
	logic [1:0] sdio_sync_reg;
	logic       sclk_prev_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cs_sync_reg   <= 2'h3;
			sclk_sync_reg <= 2'h3;
			sdi_sync_reg  <= 2'h3;
			sdio_sync_reg <= 2'h3;
			sclk_prev_reg <= 1'b1;
		end else begin
			cs_sync_reg   <= {cs_sync_reg[0], cs_n};
			sclk_sync_reg <= {sclk_sync_reg[0], sclk};
			sdi_sync_reg  <= {sdi_sync_reg[0], sdi};
			sdio_sync_reg <= {sdio_sync_reg[0], sdio_in};
			sclk_prev_reg <= sclk_sync_reg[1];
		end
	end

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic        cs_act;
	logic        rise;
	logic        fall;
	logic        three_wire;
	logic        din;
	logic [7:0]  fmt_reg;
	assign cs_act     = ~cs_sync_reg[1];
	assign rise       = cs_act & sclk_sync_reg[1] & ~sclk_prev_reg;
	assign fall       = cs_act & ~sclk_sync_reg[1] & sclk_prev_reg;
	assign three_wire = fmt_reg[WIRE_MODE_BIT];
	assign din        = three_wire ? sdio_sync_reg[1] : sdi_sync_reg[1];
	assign twi_enable = cs_sync_reg[1];

	// ------------------------------------------------------------
	// Shifter and sequencer
	// ------------------------------------------------------------
	assp_state_e       state_reg;
	assp_state_e       state_next;
	logic [2:0]        cnt_reg;
	logic [7:0]        sh_reg;
	logic [7:0]        tx_reg;
	logic              read_reg;
	logic              multi_byte_flag_reg;
	logic              out_reg;
	logic              drive_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [7:0]        byte_in;
	logic              byte_done;
	assign byte_in   = {sh_reg[6:0], din};
	assign byte_done = rise & (cnt_reg == BIT_LAST);
	assign rd_addr   = addr_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ASSP_IDLE: state_next = cs_act ? ASSP_CMD : ASSP_IDLE;
			ASSP_CMD:  state_next = byte_done ? ASSP_DATA : ASSP_CMD;
			ASSP_DATA: state_next = ASSP_DATA;
			default:   state_next = ASSP_IDLE;
		endcase
		if (!cs_act) begin
			state_next = ASSP_IDLE;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= ASSP_IDLE;
			cnt_reg   <= 3'h0;
			sh_reg    <= 8'h00;
			read_reg  <= 1'b0;
			multi_byte_flag_reg <= 1'b0;
			addr_reg  <= '0;
		end else begin
			state_reg <= state_next;
			if (!cs_act) begin
				cnt_reg <= 3'h0;
			end else if (rise) begin
				cnt_reg <= cnt_reg + 3'h1;
				sh_reg  <= byte_in;
			end
			if (byte_done && state_reg == ASSP_CMD) begin
				read_reg <= byte_in[CMD_RW_BIT];
				multi_byte_flag_reg <= byte_in[CMD_MULTI_BYTE_BIT];
				addr_reg <= byte_in[ADDR_W-1:0];
			end else if (byte_done && state_reg == ASSP_DATA && multi_byte_flag_reg) begin
				addr_reg <= addr_reg + 6'h01;
			end
		end
	end

	// Write strobe and the port's own wire-mode bit.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr       <= '0;
			wr_valid <= 1'b0;
			fmt_reg  <= OUT_FORMAT_RESET;
		end else begin
			wr_valid <= byte_done && state_reg == ASSP_DATA && !read_reg;
			if (byte_done && state_reg == ASSP_DATA && !read_reg) begin
				wr <= '{write: 1'b1, addr: addr_reg, data: byte_in};
				if (addr_reg == OUT_FORMAT_ADDR) begin
					fmt_reg <= byte_in;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Output shifter
	// ------------------------------------------------------------
	logic data_phase;
	assign data_phase = (state_reg == ASSP_DATA) & read_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_reg    <= 8'h00;
			out_reg   <= 1'b0;
			drive_reg <= 1'b0;
		end else if (!cs_act) begin
			drive_reg <= 1'b0;
		end else if (fall) begin
			if (cnt_reg == 3'h0 && data_phase) begin
				out_reg <= rd_data[7];
				tx_reg  <= {rd_data[6:0], 1'b0};
			end else begin
				out_reg <= tx_reg[7];
				tx_reg  <= {tx_reg[6:0], 1'b0};
			end
			drive_reg <= data_phase | ~three_wire;
		end
	end
	assign sdo      = out_reg;
	assign sdo_oe   = drive_reg & ~three_wire & cs_act;
	assign sdio_out = out_reg;
	assign sdio_oe  = drive_reg & three_wire & data_phase & cs_act;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence cs_rises_s;
		$rose(cs_sync_reg[1]);
	endsequence
	sdo_release_a: assert property (@(posedge clock) disable iff (rst)
		cs_rises_s |-> !sdo_oe && !sdio_oe) else $error("output driven after deselect");
	sdio_read_a: assert property (@(posedge clock) disable iff (rst)
		sdio_oe |-> three_wire && read_reg && state_reg == ASSP_DATA) else $error("sdio driven outside read");
	twi_mode_a: assert property (@(posedge clock) disable iff (rst)
		twi_enable == cs_sync_reg[1]) else $error("mode select wrong");
	addr_incr_a: assert property (@(posedge clock) disable iff (rst)
		byte_done && state_reg == ASSP_DATA && multi_byte_flag_reg && cs_act |=> addr_reg == $past(addr_reg) + 6'h01)
		else $error("address not advanced");
	hold_addr_a: assert property (@(posedge clock) disable iff (rst)
		byte_done && state_reg == ASSP_DATA && !multi_byte_flag_reg |=> $stable(addr_reg)) else $error("address moved");
	wire_mode_a: assert property (@(posedge clock) disable iff (rst)
		wr_valid && wr.addr == OUT_FORMAT_ADDR |-> three_wire == wr.data[WIRE_MODE_BIT])
		else $error("wire mode not taken");
	out_edge_a: assert property (@(posedge clock) disable iff (rst)
		!fall && cs_act && $past(cs_act) |=> $stable(out_reg)) else $error("output moved off falling edge");
	cmd_decode_a: assert property (@(posedge clock) disable iff (rst)
		byte_done && state_reg == ASSP_CMD && cs_act |=> read_reg == $past(byte_in[CMD_RW_BIT]) && state_reg == ASSP_DATA)
		else $error("command byte not decoded");
	frame_cut_a: assert property (@(posedge clock) disable iff (rst)
		!cs_act |=> state_reg == ASSP_IDLE && cnt_reg == 3'h0) else $error("partial byte kept after deselect");
	sdo_three_a: assert property (@(posedge clock) disable iff (rst)
		three_wire |-> !sdo_oe) else $error("separate output driven in three-wire mode");
	wr_pulse_a: assert property (@(posedge clock) disable iff (rst)
		wr_valid |=> !wr_valid) else $error("write strobe longer than one cycle");
	idle_quiet_a: assert property (@(posedge clock) disable iff (rst)
		!cs_act |-> !sdo_oe && !sdio_oe && !rise && !fall) else $error("serial activity while deselected");
endmodule // assp_port

// ---- shared/assp_pkg.sv ----
/*
 Constants and carrier types of the accelerometer serial slave port.
 Assumes a single 50 MHz system clock; the serial clock is a sampled input.
*/
package assp_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [5:0] OUT_FORMAT_ADDR   = 6'h31;
	localparam int         WIRE_MODE_BIT     = 6;
	localparam logic [7:0] OUT_FORMAT_RESET  = 8'h00;
	localparam int         ADDR_W            = 6;
	localparam int         CMD_RW_BIT        = 7;
	localparam int         CMD_MULTI_BYTE_BIT = 6;
	localparam logic [2:0] BIT_LAST          = 3'h7;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLOCK_HZ        = 50000000;
	localparam int SCLK_MAX_HZ     = 5000000;
	localparam int SCLK_MIN_CYCLES = CLOCK_HZ / SCLK_MAX_HZ;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ASSP_IDLE = 3'b001,
		ASSP_CMD  = 3'b010,
		ASSP_DATA = 3'b100
	} assp_state_e;

	typedef struct packed {
		logic             write;
		logic [ADDR_W-1:0] addr;
		logic [7:0]       data;
	} assp_wr_s;
endpackage

// ---- testbench/assp_master.sv ----
/*
 Serial bus master model: mode-3 frames at a 160 ns bit period.
 Assumes the bench wires miso to the selected data return line.
*/
`timescale 1ns/1ps
module assp_master (
	// Serial pins
	output logic      cs_n,
	output logic      sclk,
	output logic      mosi,
	output logic      mosi_oe,
	// Returned data
	input  wire logic miso
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b1;
		mosi = 1'b1;
		mosi_oe = 1'b1;
	end
	task automatic shift(input logic [7:0] tx, input logic drv, output logic [7:0] rxb);
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b0;
			mosi_oe = drv;
			mosi = tx[i];
			#80;
			sclk = 1'b1;
			rxb[i] = miso;
			#80;
		end
	endtask
	task automatic frame(input logic [7:0] cmd, input int n, input logic three, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [7:0] b;
		rd = '0;
		cs_n = 1'b0;
		#80;
		shift(cmd, 1'b1, b);
		for (int k = 0; k < n; k++) begin
			shift(wd[8*k+:8], !(three && cmd[7]), b);
			rd[8*k+:8] = b;
		end
		#80;
		cs_n = 1'b1;
		mosi_oe = 1'b1;
		mosi = 1'b1;
		#200;
	endtask
endmodule // assp_master

// ---- testbench/tb_accel_serial_slave_port.sv ----
/*
 Self-checking bench of the serial slave port.
 Assumes register storage answers rd_data from rd_addr with a fixed pattern.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t bad value", $time); end end
module tb_accel_serial_slave_port;
	import assp_pkg::*;
	logic             clock = 1'b0;
	logic             rst = 1'b1;
	logic             mode3 = 1'b0;
	int               error_cnt = 0;
	int               comparisons = 0;
	int               oe_hits = 0;
	logic [31:0]      rx;
	logic [13:0]      rows [4] = '{{6'h00, 8'hA5}, {6'h3F, 8'h5A}, {6'h12, 8'hFF}, {6'h31, 8'h00}};
	wire              cs_n, sclk, mosi, mosi_oe, sdo, sdo_oe, sdio_out, sdio_oe, twi_enable, wr_valid;
	wire [ADDR_W-1:0] rd_addr;
	assp_wr_s         wr;
	assp_wr_s         got [$];
	// Both data lines are pulled up when nobody drives them.
	wire              sdio_line = sdio_oe ? sdio_out : (mosi_oe ? mosi : 1'b1);
	wire              miso = mode3 ? sdio_line : (sdo_oe ? sdo : 1'b1);

	function automatic logic [7:0] exp_rd(logic [5:0] a);
		return {a, 2'b01} ^ 8'h3C;
	endfunction

	always #10 clock = ~clock;
	always @(posedge clock) begin
		if (wr_valid) got.push_back(wr);
		if (sdio_oe) oe_hits++;
	end

	assp_master m (.cs_n(cs_n), .sclk(sclk), .mosi(mosi), .mosi_oe(mosi_oe), .miso(miso));
	assp_port dut (.clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(mosi), .sdo(sdo), .sdo_oe(sdo_oe),
		.sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .twi_enable(twi_enable),
		.rd_addr(rd_addr), .rd_data(exp_rd(rd_addr)), .wr(wr), .wr_valid(wr_valid));

	task automatic xfer(input logic [7:0] cmd, input int n, input logic [31:0] wd);
		@(posedge clock);
		#7;
		m.frame(cmd, n, mode3, wd, rx);
	endtask
	task automatic pop_chk(input logic [14:0] e);
		assp_wr_s g;
		g = got.size() ? got.pop_front() : '0;
		`CHK(g, e)
	endtask
	task close_out;
		if (error_cnt == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clock);
		#7 rst = 1'b0;
		`CHK({sdo_oe, sdio_oe, twi_enable, rd_addr, wr}, {3'b001, 6'h00, 15'h0000})
		repeat (3) @(posedge clock);
		foreach (rows[i]) begin
			xfer({2'b00, rows[i][13:8]}, 1, {24'h0, rows[i][7:0]});
			pop_chk({1'b1, rows[i]});
		end
		// Burst write wraps the six-bit address.
		xfer(8'h7E, 3, 32'h00332211);
		pop_chk({1'b1, 6'h3E, 8'h11});
		pop_chk({1'b1, 6'h3F, 8'h22});
		pop_chk({1'b1, 6'h00, 8'h33});
		xfer(8'hFF, 2, 32'h0);
		`CHK(rx[15:0], {exp_rd(6'h00), exp_rd(6'h3F)})
		`CHK(got.size(), 0)
		`CHK({sdo_oe, twi_enable}, 2'b01)
		// Switch to the shared data line.
		xfer(8'h31, 1, 32'h40);
		pop_chk({1'b1, 6'h31, 8'h40});
		mode3 = 1'b1;
		oe_hits = 0;
		xfer(8'h05, 1, 32'h0);
		pop_chk({1'b1, 6'h05, 8'h00});
		`CHK(oe_hits, 0)
		xfer(8'h85, 1, 32'h0);
		`CHK(rx[7:0], exp_rd(6'h05))
		`CHK(oe_hits != 0, 1'b1)
		`CHK({sdo_oe, sdio_oe, twi_enable}, 3'b001)
		close_out;
	end

	initial begin
		repeat (100000) @(posedge clock);
		error_cnt++;
		close_out;
	end
endmodule // tb_accel_serial_slave_port
